// ### rpta_defines.vh
// constants shared by the ring protection table assist
`ifndef RPTA_DEFINES_VH
`define RPTA_DEFINES_VH
`define RPTA_VID_W      12
`define RPTA_VDEPTH     4096
`define RPTA_GRP_W      16
`define RPTA_PORT_W     11
`define RPTA_FID_W      17
`define RPTA_VENT_W     44
`define RPTA_MENT_W     29
`define RPTA_MADDR_W    10
`define RPTA_MDEPTH     1024
`define RPTA_NFID       16
`define RPTA_FID_UNUSED 17'h1FFFF
`define RPTA_PORTN_W    4
`define RPTA_GRP_LSB    28
`define RPTA_PM_LSB     17
`define RPTA_FID_LSB    0
`define RPTA_MVALID_BIT 28
`define RPTA_MPORT_LSB  17
`define RPTA_MADDR_MAX  10'h3FF
`endif

// ### rpta_ram.v
// single-port table memory with registered read data
`timescale 1ns/100ps
module rpta_ram
#(
   parameter AW = 12,
   parameter DW = 44
)
(
   input  wire          clock,
   input  wire          we,
   input  wire [AW-1:0] addr,
   input  wire [DW-1:0] wdata,
   output reg  [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clock)
   begin
      if (we)
         mem[addr] <= wdata;
      rdata <= mem[addr];
   end
endmodule // rpta_ram

// ### rpta_top.v
// ring protection table assist: bulk vlan updater and address flush scan
`timescale 1ns/100ps
`include "rpta_defines.vh"
// Summary of operation
// - vlan entry holds groups, members, identifier
// - ring group field is sixteen bits
// - eleven bit member bitmap, every bit selectable
// - masked update touches only entries whose groups or members overlap the mask
// - group enable decides if mask selects
// - update walks first through last address
// - or port set mask into members
// - update trigger self clears when done
// - filter ports drop non member frames
// - sixteen identifiers, 0x1FFFF matches nothing
// - list enable matches against identifier list
// - filter enable restricts to selected identifiers
// - access identifier 0x1FFFF means unused
// - port filter limits to masked ports
// - remove found deletes matching entries
// - flush trigger self clears when done
// - optional pulse on flush completion
// - both engines may run together
module rpta_top
(
   input  wire                              clock,
   input  wire                              rst,
   // vlan update control
   input  wire                              update_trigger_set,
   input  wire [`RPTA_GRP_W+`RPTA_PORT_W-1:0] group_select_mask,
   input  wire                              group_select_enable,
   input  wire [`RPTA_VID_W-1:0]            update_first_address,
   input  wire [`RPTA_VID_W-1:0]            update_last_address,
   input  wire [`RPTA_PORT_W-1:0]           port_set_mask,
   output wire                              update_trigger,
   // flush control
   input  wire                              table_access_trigger_set,
   input  wire                              scan_identifier_list_enable,
   input  wire [`RPTA_NFID*`RPTA_FID_W-1:0] scan_identifier_list,
   input  wire                              scan_identifier_filter_enable,
   input  wire [`RPTA_FID_W-1:0]            access_entry_identifier,
   input  wire                              scan_port_filter_enable,
   input  wire [`RPTA_PORT_W-1:0]           scan_port_filter_mask,
   input  wire                              remove_found_enable,
   input  wire                              flush_done_irq_enable,
   output wire                              table_access_trigger,
   output reg                               flush_done_irq_r,
   // software vlan table write
   input  wire                              vlan_wr,
   input  wire [`RPTA_VID_W-1:0]            vlan_wr_addr,
   input  wire [`RPTA_VENT_W-1:0]           vlan_wr_data,
   // address table learn write
   input  wire                              mac_wr,
   input  wire [`RPTA_MADDR_W-1:0]          mac_wr_addr,
   input  wire [`RPTA_MENT_W-1:0]           mac_wr_data,
   // ingress filter lookup
   input  wire                              lookup_req,
   input  wire [`RPTA_VID_W-1:0]            lookup_vid,
   input  wire [`RPTA_PORT_W-1:0]           ingress_vlan_filter_ports,
   input  wire [`RPTA_PORTN_W-1:0]          lookup_port,
   output reg                               lookup_valid_r,
   output reg                               lookup_drop_r,
   output wire                              lookup_ready
);
   localparam [3:0] U_IDLE = 4'h1;
   localparam [3:0] U_RD   = 4'h2;
   localparam [3:0] U_WAIT = 4'h4;
   localparam [3:0] U_WR   = 4'h8;
   localparam [3:0] F_IDLE = 4'h1;
   localparam [3:0] F_RD   = 4'h2;
   localparam [3:0] F_WAIT = 4'h4;
   localparam [3:0] F_CHK  = 4'h8;

   // identifier equality, unused slot never matches
   function fid_hit;
      input [`RPTA_FID_W-1:0] a;
      input [`RPTA_FID_W-1:0] b;
      begin
         fid_hit = (a == b) && (a != `RPTA_FID_UNUSED);
      end
   endfunction

   reg  [3:0]                    ust_r;
   reg  [3:0]                    ust_nxt;
   reg  [`RPTA_VID_W-1:0]        uaddr_r;
   reg  [`RPTA_VID_W-1:0]        ulast_r;
   reg  [`RPTA_GRP_W+`RPTA_PORT_W-1:0] umask_r;
   reg                           uena_r;
   reg  [`RPTA_PORT_W-1:0]       uset_r;
   reg                           ubusy_r;
   reg  [3:0]                    fst_r;
   reg  [3:0]                    fst_nxt;
   reg  [`RPTA_MADDR_W-1:0]      faddr_r;
   reg  [`RPTA_NFID*`RPTA_FID_W-1:0] flist_r;
   reg                           flist_en_r;
   reg                           ffilt_en_r;
   reg  [`RPTA_FID_W-1:0]        fsingle_r;
   reg                           fpen_r;
   reg  [`RPTA_PORT_W-1:0]       fpmask_r;
   reg                           frem_r;
   reg                           fbusy_r;
   reg  [`RPTA_PORTN_W-1:0]      lk_pn_r;
   reg  [`RPTA_PORT_W-1:0]       lk_filt_r;
   reg                           lk_pend_r;

   wire [`RPTA_VENT_W-1:0]       vrd;
   wire [`RPTA_MENT_W-1:0]       mrd;
   reg                           vwe;
   reg  [`RPTA_VID_W-1:0]        vaddr;
   reg  [`RPTA_VENT_W-1:0]       vwdata;
   reg                           mwe;
   reg  [`RPTA_MADDR_W-1:0]      maddr;
   reg  [`RPTA_MENT_W-1:0]       mwdata;

   // entry fields
   wire [`RPTA_GRP_W-1:0]  v_grp =
      vrd[`RPTA_GRP_LSB+`RPTA_GRP_W-1:`RPTA_GRP_LSB];
   wire [`RPTA_PORT_W-1:0] v_pm  =
      vrd[`RPTA_PM_LSB+`RPTA_PORT_W-1:`RPTA_PM_LSB];
   wire [`RPTA_FID_W-1:0]  m_fid =
      mrd[`RPTA_FID_LSB+`RPTA_FID_W-1:`RPTA_FID_LSB];
   wire [`RPTA_PORT_W-1:0] m_port =
      mrd[`RPTA_MPORT_LSB+`RPTA_PORT_W-1:`RPTA_MPORT_LSB];
   wire                    m_valid = mrd[`RPTA_MVALID_BIT];

   // all member bitmap bits act as extra group selectors
   wire u_sel = !uena_r ||
      (|({v_grp, v_pm} & umask_r));

   // identifier list compare, one slot per generate lane
   wire [`RPTA_NFID-1:0] slot_hit;
   genvar gi;
   generate
      for (gi = 0; gi < `RPTA_NFID; gi = gi + 1)
      begin : g_slot
         assign slot_hit[gi] = fid_hit(
            flist_r[gi*`RPTA_FID_W +: `RPTA_FID_W], m_fid);
      end
   endgenerate

   wire f_idsel = (flist_en_r ? (|slot_hit) : 1'b0) |
                  fid_hit(fsingle_r, m_fid);
   wire f_idok  = !ffilt_en_r || f_idsel;
   wire f_pok   = !fpen_r || (|(m_port & fpmask_r));
   wire f_match = m_valid && f_idok && f_pok;

   assign update_trigger       = ubusy_r;
   assign table_access_trigger = fbusy_r;
   // updater owns the vlan port for its whole run, so lookups wait
   assign lookup_ready = (ust_r == U_IDLE) && !vlan_wr;

   rpta_ram #(.AW(`RPTA_VID_W), .DW(`RPTA_VENT_W)) u_vlan
   (
      .clock (clock),
      .we    (vwe),
      .addr  (vaddr),
      .wdata (vwdata),
      .rdata (vrd)
   );

   rpta_ram #(.AW(`RPTA_MADDR_W), .DW(`RPTA_MENT_W)) u_mac
   (
      .clock (clock),
      .we    (mwe),
      .addr  (maddr),
      .wdata (mwdata),
      .rdata (mrd)
   );

   // vlan port arbitration: updater, then software, then lookup
   always @*
   begin
      vwe    = 1'b0;
      vaddr  = lookup_vid;
      vwdata = vrd;
      if (ust_r != U_IDLE)
      begin
         vaddr = uaddr_r;
         if (ust_r == U_WR && u_sel)
         begin
            vwe    = 1'b1;
            vwdata = vrd;
            vwdata[`RPTA_PM_LSB+`RPTA_PORT_W-1:`RPTA_PM_LSB] =
               v_pm | uset_r;
         end
      end
      else if (vlan_wr)
      begin
         vwe    = 1'b1;
         vaddr  = vlan_wr_addr;
         vwdata = vlan_wr_data;
      end
   end

   always @*
   begin
      ust_nxt = ust_r;
      case (ust_r)
         U_IDLE: if (update_trigger_set && !ubusy_r) ust_nxt = U_RD;
         U_RD:   ust_nxt = U_WAIT;
         U_WAIT: ust_nxt = U_WR;
         U_WR:   ust_nxt = (uaddr_r == ulast_r) ? U_IDLE : U_RD;
         default: ust_nxt = U_IDLE;
      endcase
   end

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ust_r   <= U_IDLE;
         uaddr_r <= {`RPTA_VID_W{1'b0}};
         ulast_r <= {`RPTA_VID_W{1'b0}};
         umask_r <= {(`RPTA_GRP_W+`RPTA_PORT_W){1'b0}};
         uena_r  <= 1'b0;
         uset_r  <= {`RPTA_PORT_W{1'b0}};
         ubusy_r <= 1'b0;
      end
      else
      begin
         ust_r <= ust_nxt;
         if (ust_r == U_IDLE && update_trigger_set && !ubusy_r)
         begin
            ubusy_r <= 1'b1;
            uaddr_r <= update_first_address;
            ulast_r <= update_last_address;
            umask_r <= group_select_mask;
            uena_r  <= group_select_enable;
            uset_r  <= port_set_mask;
         end
         else if (ust_r == U_WR)
         begin
            if (uaddr_r == ulast_r)
               ubusy_r <= 1'b0;
            else
               uaddr_r <= uaddr_r + 1'b1;
         end
      end
   end

   // address table port: flush scan has priority over learning
   always @*
   begin
      mwe    = 1'b0;
      maddr  = faddr_r;
      mwdata = mrd;
      if (fst_r == F_CHK)
      begin
         if (f_match && frem_r)
         begin
            mwe    = 1'b1;
            mwdata = {`RPTA_MENT_W{1'b0}};
         end
      end
      else if (fst_r == F_IDLE && mac_wr)
      begin
         mwe    = 1'b1;
         maddr  = mac_wr_addr;
         mwdata = mac_wr_data;
      end
   end

   always @*
   begin
      fst_nxt = fst_r;
      case (fst_r)
         F_IDLE: if (table_access_trigger_set && !fbusy_r) fst_nxt = F_RD;
         F_RD:   fst_nxt = F_WAIT;
         F_WAIT: fst_nxt = F_CHK;
         F_CHK:  fst_nxt = (faddr_r == `RPTA_MADDR_MAX) ? F_IDLE : F_RD;
         default: fst_nxt = F_IDLE;
      endcase
   end

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fst_r      <= F_IDLE;
         faddr_r    <= {`RPTA_MADDR_W{1'b0}};
         flist_r    <= {(`RPTA_NFID*`RPTA_FID_W){1'b0}};
         flist_en_r <= 1'b0;
         ffilt_en_r <= 1'b0;
         fsingle_r  <= {`RPTA_FID_W{1'b0}};
         fpen_r     <= 1'b0;
         fpmask_r   <= {`RPTA_PORT_W{1'b0}};
         frem_r     <= 1'b0;
         fbusy_r    <= 1'b0;
         flush_done_irq_r <= 1'b0;
      end
      else
      begin
         fst_r <= fst_nxt;
         flush_done_irq_r <= 1'b0;
         if (fst_r == F_IDLE && table_access_trigger_set && !fbusy_r)
         begin
            fbusy_r    <= 1'b1;
            faddr_r    <= {`RPTA_MADDR_W{1'b0}};
            flist_r    <= scan_identifier_list;
            flist_en_r <= scan_identifier_list_enable;
            ffilt_en_r <= scan_identifier_filter_enable;
            fsingle_r  <= access_entry_identifier;
            fpen_r     <= scan_port_filter_enable;
            fpmask_r   <= scan_port_filter_mask;
            frem_r     <= remove_found_enable;
         end
         else if (fst_r == F_CHK)
         begin
            if (faddr_r == `RPTA_MADDR_MAX)
            begin
               fbusy_r          <= 1'b0;
               flush_done_irq_r <= flush_done_irq_enable;
            end
            else
               faddr_r <= faddr_r + 1'b1;
         end
      end
   end

   // ingress filter: data returns two cycles after an accepted lookup
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lk_pend_r      <= 1'b0;
         lk_pn_r        <= {`RPTA_PORTN_W{1'b0}};
         lk_filt_r      <= {`RPTA_PORT_W{1'b0}};
         lookup_valid_r <= 1'b0;
         lookup_drop_r  <= 1'b0;
      end
      else
      begin
         lk_pend_r      <= lookup_req && lookup_ready;
         lk_pn_r        <= lookup_port;
         lk_filt_r      <= ingress_vlan_filter_ports;
         lookup_valid_r <= lk_pend_r;
         lookup_drop_r  <= lk_pend_r && lk_filt_r[lk_pn_r] &&
                           !v_pm[lk_pn_r];
      end
   end
   // engines use separate tables, so they run side by side
endmodule // rpta_top

// ### rpta_top_sva.sv
// concurrent checks on the table assist ports
`timescale 1ns/100ps
module rpta_chk
(
   input wire        clock,
   input wire        rst,
   input wire        update_trigger_set,
   input wire [11:0] update_first_address,
   input wire [11:0] update_last_address,
   input wire        update_trigger,
   input wire        table_access_trigger_set,
   input wire        table_access_trigger,
   input wire        flush_done_irq_enable,
   input wire        flush_done_irq_r,
   input wire        lookup_req,
   input wire        lookup_ready,
   input wire        lookup_valid_r
);
   reg  [14:0] ucnt_r;
   reg  [14:0] ulen_r;
   reg  [11:0] fcnt_r;
   wire        take_w = lookup_req & lookup_ready;
   // expected length frozen while busy, as the run latches its range
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ucnt_r <= 15'h0;
         ulen_r <= 15'h0;
         fcnt_r <= 12'h0;
      end
      else
      begin
         ucnt_r <= update_trigger ? ucnt_r + 15'h1 : 15'h0;
         fcnt_r <= table_access_trigger ? fcnt_r + 12'h1 : 12'h0;
         if (!update_trigger)
            ulen_r <= 15'h3 * (update_last_address - update_first_address
               + 15'h1);
      end
   end
   default clocking dc @(posedge clock); endclocking
   default disable iff (rst);
   a_upd_start: assert property (update_trigger_set && !update_trigger
      |=> update_trigger) else $error("update did not start");
   a_upd_len: assert property ($fell(update_trigger)
      |-> ucnt_r == ulen_r) else $error("update length wrong");
   a_flush_start: assert property (table_access_trigger_set
      && !table_access_trigger |=> table_access_trigger)
      else $error("flush did not start");
   a_flush_len: assert property ($fell(table_access_trigger)
      |-> fcnt_r == 12'hC00) else $error("flush length wrong");
   a_irq_end: assert property ($fell(table_access_trigger)
      && flush_done_irq_enable |-> flush_done_irq_r)
      else $error("flush end without pulse");
   a_irq_cause: assert property (flush_done_irq_r
      |-> $fell(table_access_trigger)) else $error("stray flush pulse");
   a_lk_latency: assert property (take_w |-> ##2 lookup_valid_r)
      else $error("lookup answer late");
   a_lk_cause: assert property (lookup_valid_r |-> $past(take_w, 2))
      else $error("lookup answer unrequested");
   a_lk_blocked: assert property (update_trigger |-> !lookup_ready)
      else $error("lookup open during update");
   c_upd: cover property ($fell(update_trigger));
   c_irq: cover property (flush_done_irq_r);
   c_both: cover property (update_trigger && table_access_trigger);
endmodule // rpta_chk

bind rpta_top rpta_chk u_chk (.clock, .rst, .update_trigger_set,
   .update_first_address, .update_last_address, .update_trigger,
   .table_access_trigger_set, .table_access_trigger,
   .flush_done_irq_enable, .flush_done_irq_r, .lookup_req,
   .lookup_ready, .lookup_valid_r);

// ### tb_rpta_top.sv
// self-checking bench for the table assist
`timescale 1ns/100ps
module tb_rpta_top;
   reg          clock = 1'h0, rst = 1'h1, us = 1'h0, ge = 1'h0, ts = 1'h0;
   reg          le = 1'h0, fe = 1'h0, pe = 1'h0, re = 1'h0, ie = 1'h0;
   reg          vw = 1'h0, mw = 1'h0, lr = 1'h0;
   reg  [26:0]  gm = 27'h0;
   reg  [11:0]  fa = 12'h0, la = 12'h0, va = 12'h0, lv = 12'h0;
   reg  [10:0]  sm = 11'h0, pf = 11'h0, fp = 11'h0;
   reg  [271:0] sl = {16{17'h1FFFF}};
   reg  [16:0]  ai = 17'h1FFFF;
   reg  [43:0]  vd = 44'h0;
   reg  [9:0]   ma = 10'h0;
   reg  [28:0]  md = 29'h0;
   reg  [3:0]   lp = 4'h0;
   reg  [16:0]  fv;
   wire         ut, tt, irq, lkv, lkd, lkr;
   reg  [15:0]  mg [0:63];
   reg  [10:0]  mp [0:63];
   integer      num_errors = 0, n_checks = 0, i, k;
   rpta_top dut (.clock(clock), .rst(rst), .update_trigger_set(us),
      .group_select_mask(gm), .group_select_enable(ge),
      .update_first_address(fa), .update_last_address(la),
      .port_set_mask(sm), .update_trigger(ut),
      .table_access_trigger_set(ts), .scan_identifier_list_enable(le),
      .scan_identifier_list(sl), .scan_identifier_filter_enable(fe),
      .access_entry_identifier(ai), .scan_port_filter_enable(pe),
      .scan_port_filter_mask(pf), .remove_found_enable(re),
      .flush_done_irq_enable(ie), .table_access_trigger(tt),
      .flush_done_irq_r(irq), .vlan_wr(vw), .vlan_wr_addr(va),
      .vlan_wr_data(vd), .mac_wr(mw), .mac_wr_addr(ma), .mac_wr_data(md),
      .lookup_req(lr), .lookup_vid(lv), .ingress_vlan_filter_ports(fp),
      .lookup_port(lp), .lookup_valid_r(lkv), .lookup_drop_r(lkd),
      .lookup_ready(lkr));
   initial
      forever #5 clock = ~clock;
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
   begin
      n_checks = n_checks + 1;
      if (s !== e)
      begin
         num_errors = num_errors + 1;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   end
   endtask
   task close_out;
   begin
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   task looks(input integer a, input integer b);
   begin
      for (i = a; i <= b; i = i + 1)
      begin
         lp = $urandom % 11;
         lr = 1'h1;
         lv = i;
         @(negedge clock);
         lr = 1'h0;
         k = 0;
         while (lkv !== 1'h1 && k < 8)
         begin
            @(negedge clock);
            k = k + 1;
         end
         chk("valid", lkv, 1);
         chk("drop", lkd, fp[lp] & ~mp[i][lp]);
         @(negedge clock);
      end
   end
   endtask
   task upd(input e, input [26:0] m, input integer a, input integer b);
   begin
      ge = e;
      gm = m;
      fa = a;
      la = b;
      sm = $urandom;
      us = 1'h1;
      @(negedge clock);
      us = 1'h0;
      @(negedge clock);
      chk("busy", ut, 1);
      // a restart and a table write while busy must both be dropped
      us = 1'h1;
      fa = 12'h0;
      vw = 1'h1;
      va = a;
      vd = 44'h0;
      @(negedge clock);
      us = 1'h0;
      vw = 1'h0;
      k = 0;
      while (ut === 1'h1 && k < 20000)
      begin
         @(negedge clock);
         k = k + 1;
      end
      chk("done", ut, 0);
      for (i = a; i <= b; i = i + 1)
         if (!e || (mg[i] & m[26:11]) || (mp[i] & m[10:0]))
            mp[i] = mp[i] | sm;
   end
   endtask
   task flush(input e);
   begin
      ie = e;
      ts = 1'h1;
      @(negedge clock);
      ts = 1'h0;
   end
   endtask
   task wflush(input e);
   begin
      k = 0;
      while (tt === 1'h1 && k < 4000)
      begin
         @(negedge clock);
         k = k + 1;
      end
      chk("flush", tt, 0);
      chk("pulse", irq, e);
   end
   endtask
   initial
   begin
      k = $urandom(32'h7A0DE44F);
      repeat (3) @(posedge clock);
      @(negedge clock);
      rst = 1'h0;
      chk("idle", {ut, tt, irq, lkv}, 0);
      for (i = 4; i <= 56; i = i + 1)
      begin
         mg[i] = $urandom & 16'h0003;
         mp[i] = $urandom;
         vw = 1'h1;
         va = i;
         fv = i;
         vd = {mg[i], mp[i], fv};
         @(negedge clock);
      end
      vw = 1'h0;
      fp = $urandom;
      looks(4, 56);
      $display("test filter done");
      upd(1'h1, 27'h0001000, 10, 50);
      looks(4, 56);
      upd(1'h1, 27'h0000080, 20, 23);
      upd(1'h0, 27'h0, 30, 31);
      looks(18, 33);
      $display("test update done");
      for (i = 0; i < 4; i = i + 1)
      begin
         mw = 1'h1;
         ma = i;
         fv = i + 10;
         md = {1'h1, 11'h180, fv};
         @(negedge clock);
      end
      mw = 1'h0;
      {le, fe, pe, re} = 4'hF;
      sl[16:0] = 17'h0000A;
      pf = 11'h180;
      flush(1'h1);
      // a learn write while the scan runs must be dropped
      mw = 1'h1;
      ma = 10'h2;
      md = 29'h0;
      @(negedge clock);
      mw = 1'h0;
      upd(1'h1, 27'h0000800, 4, 9);
      wflush(1'h1);
      chk("flushed", dut.u_mac.mem[0], 0);
      chk("kept1", dut.u_mac.mem[1], {1'h1, 11'h180, 17'h0000B});
      chk("kept2", dut.u_mac.mem[2], {1'h1, 11'h180, 17'h0000C});
      looks(4, 9);
      $display("test parallel done");
      {le, fe, pe, re} = 4'h1;
      flush(1'h0);
      wflush(1'h0);
      for (i = 1; i < 4; i = i + 1)
         chk("cleared", dut.u_mac.mem[i], 0);
      $display("test flush done");
      close_out;
   end
   initial
   begin
      #400000;
      num_errors = num_errors + 1;
      close_out;
   end
endmodule // tb_rpta_top
